// file: hdl/wdt_dout_cmd_defs.vh
// Constants for the digital output and host watchdog command interpreter
`ifndef WDT_DOUT_CMD_DEFS_VH
`define WDT_DOUT_CMD_DEFS_VH

// ****************************************
// Characters of the command language
// ****************************************
`define CH_CR     8'h0d
`define CH_HASH   8'h23
`define CH_TILDE  8'h7e
`define CH_STAR   8'h2a
`define CH_GT     8'h3e
`define CH_QUEST  8'h3f
`define CH_BANG   8'h21
`define CH_ZERO   8'h30
`define CH_ONE    8'h31
`define CH_TWO    8'h32
`define CH_THREE  8'h33
`define CH_FOUR   8'h34
`define CH_FIVE   8'h35
`define CH_P      8'h50
`define CH_S      8'h53

// ****************************************
// Module address field, fixed to 01
// ****************************************
`define ADDR_HI   8'h30
`define ADDR_LO   8'h31

// ****************************************
// Frame lengths without checksum
// ****************************************
`define LEN_KICK  4'h3
`define LEN_SHORT 4'h4
`define LEN_SAVE  4'h5
`define LEN_LONG  4'h7
`define LEN_CHK   4'h2
`define BUF_DEPTH 9

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL    12'h000
`define OFS_STATUS  12'h004
`define OFS_SAFE    12'h008
`define OFS_PWRON   12'h00c

// ****************************************
// Field positions
// ****************************************
`define CTRL_EN_BIT     0
`define CTRL_IV_LSB     8
`define STAT_TO_BIT     0
`define STAT_DOUT_LSB   8
`define STAT_STATE_CODE 8'h04

// ****************************************
// Reset values
// ****************************************
`define RST_EN      1'b0
`define RST_IV      8'h64
`define RST_SAFE    8'h00
`define RST_PWRON   8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 10
`define WDT_STEP_NS   100000000

`endif

// file: hdl/wdt_dout_cmd.v
// ASCII command interpreter for digital outputs and host watchdog
`timescale 1ns/10ps
`include "wdt_dout_cmd_defs.vh"
// Operation
// R1: Multi-channel set: hash, address, 00, hex value
// R2: Value bit i drives output channel i
// R3: Single set: 1, channel digit, 00 or 01
// R4: Output replies are >, ? or ! only
// R5: During timeout ignore output commands, reply !
// R6: Syntax or communication errors get no reply
// R7: Only module address 01 is recognised
// R8: Keep-alive broadcast accepted, never answered
// R9: Status read returns !01 then 00 or 04
// R10: Timeout status persists until status clear
// R11: Status clear zeroes status, replies !01
// R12: Timeout read returns !01, enable, hex interval
// R13: Timeout set stores enable and interval, !01
// R14: Interval steps 0.1 s, 01 to FF
// R15: Expiry sets status, starts LED flashing
// R16: After timeout enable reads 0, interval kept
// R17: Status clear stops LED flashing
// R18: Invalid watchdog commands reply ? with address
// R19: Reset gives power-on values, timeout safe values
// R20: Host clears status before new output command
// R21: Save commands capture outputs as stored values
// R22: Carriage return end, optional checksum accepted
// R23: Keep-alive restarts counter, idle when disabled
// R24: Nonexistent channel gets invalid reply

module wdt_dout_cmd #(
    parameter CH_COUNT    = 8,
    parameter STEP_CYCLES = `WDT_STEP_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire        CLOCK_I,
    input  wire        RST_N_I,
    // Command byte stream in
    input  wire [7:0]  RX_DATA_I,
    input  wire        RX_VALID_I,
    output wire        RX_READY_O,
    // Reply byte stream out
    output wire [7:0]  TX_DATA_O,
    output wire        TX_VALID_O,
    input  wire        TX_READY_I,
    // APB register slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire        PREADY_O,
    output wire        PSLVERR_O,
    // Outputs, indicator and persistent status
    output wire [7:0]  DOUT_O,
    output wire        LED_O,
    input  wire        WDT_NV_STATUS_I,
    output wire        WDT_NV_STATUS_O
);

// ****************************************
// Helpers
// ****************************************
// Hex character to {invalid, nibble}
function [4:0] hexval;
    input [7:0] c;
    begin
        if (c >= 8'h30 && c <= 8'h39)
            hexval = {1'b0, c[3:0]};
        else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
            hexval = {1'b0, c[3:0] + 4'h9};
        else
            hexval = 5'h10;
    end
endfunction

// Nibble to upper-case hex character
function [7:0] hexchar;
    input [3:0] n;
    begin
        hexchar = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
    end
endfunction

localparam [7:0]  CH_MASK  = (8'hff >> (8 - CH_COUNT));
localparam        STEP_END = STEP_CYCLES - 1;

// ****************************************
// State
// ****************************************
reg  [7:0]  buf_mem [0:`BUF_DEPTH-1];
reg  [3:0]  cnt_reg;
reg         ovf_reg;
reg         pend_reg;
reg         start_reg;
reg  [55:0] tx_vec_reg;
reg  [2:0]  tx_left_reg;
reg         tx_valid_reg;
reg         rx_ready_reg;
reg  [7:0]  dout_reg;
reg  [7:0]  safe_reg;
reg  [7:0]  pwron_reg;
reg         en_reg;
reg  [7:0]  iv_reg;
reg         timeout_reg;
reg  [23:0] step_cnt_reg;
reg  [7:0]  iv_cnt_reg;
reg         led_reg;
reg  [31:0] prdata_reg;
reg         pready_reg;
reg         pslverr_reg;

// ****************************************
// Frame decode
// ****************************************
reg  [3:0]  base;
reg  [7:0]  sum;
reg  [4:0]  ck_hi;
reg  [4:0]  ck_lo;
reg         frame_ok;
reg  [4:0]  v_hi;
reg  [4:0]  v_lo;
reg  [7:0]  val;
reg  [55:0] rsp_vec;
reg  [2:0]  rsp_len;
reg         do_all;
reg         do_one;
reg         do_kick;
reg         do_clr;
reg         do_set;
reg         do_save_p;
reg         do_save_s;
reg  [7:0]  one_mask;
integer     i;

// Frame check and command decode
always @* begin
    base = 4'h0;
    sum = 8'h00;
    rsp_vec = 56'h0;
    rsp_len = 3'd0;
    do_all = 1'b0;
    do_one = 1'b0;
    do_kick = 1'b0;
    do_clr = 1'b0;
    do_set = 1'b0;
    do_save_p = 1'b0;
    do_save_s = 1'b0;
    one_mask = 8'h00;
    if (buf_mem[0] == `CH_HASH)
        base = `LEN_LONG;
    else if (buf_mem[0] == `CH_TILDE) begin
        if (buf_mem[1] == `CH_STAR)
            base = `LEN_KICK;
        else if (buf_mem[3] == `CH_THREE)
            base = `LEN_LONG;
        else if (buf_mem[3] == `CH_FIVE)
            base = `LEN_SAVE;
        else
            base = `LEN_SHORT;
    end
    for (i = 0; i < `BUF_DEPTH; i = i + 1) begin
        if (i < base)
            sum = sum + buf_mem[i];
    end
    ck_hi = hexval(buf_mem[base]);
    ck_lo = hexval(buf_mem[base + 4'h1]);
    frame_ok = !ovf_reg && base != 4'h0 &&
               (cnt_reg == base || (cnt_reg == base + `LEN_CHK && !ck_hi[4] && !ck_lo[4] &&
                {ck_hi[3:0], ck_lo[3:0]} == sum)); // see R22 see R6
    v_hi = hexval(buf_mem[5]);
    v_lo = hexval(buf_mem[6]);
    val = {v_hi[3:0], v_lo[3:0]};
    if (!frame_ok) begin
        rsp_len = 3'd0; // see R6
    end else if (base == `LEN_KICK) begin
        do_kick = (buf_mem[2] == `CH_STAR); // see R8
    end else if (buf_mem[1] != `ADDR_HI || buf_mem[2] != `ADDR_LO) begin
        rsp_len = 3'd0; // see R7
    end else if (buf_mem[0] == `CH_HASH) begin
        rsp_len = 3'd1; // see R4
        one_mask = 8'h01 << buf_mem[4][2:0];
        if (buf_mem[3] == `CH_ZERO && buf_mem[4] == `CH_ZERO) begin
            if (v_hi[4] || v_lo[4])
                rsp_len = 3'd0;
            else if ((val & ~CH_MASK) != 8'h00)
                rsp_vec[55:48] = `CH_QUEST;
            else if (timeout_reg)
                rsp_vec[55:48] = `CH_BANG; // see R5
            else begin
                rsp_vec[55:48] = `CH_GT;
                do_all = 1'b1; // see R1
            end
        end else if (buf_mem[3] == `CH_ONE) begin
            if (buf_mem[4] < `CH_ZERO || buf_mem[4] >= `CH_ZERO + CH_COUNT ||
                buf_mem[5] != `CH_ZERO || (buf_mem[6] != `CH_ZERO && buf_mem[6] != `CH_ONE))
                rsp_vec[55:48] = `CH_QUEST; // see R24
            else if (timeout_reg)
                rsp_vec[55:48] = `CH_BANG; // see R5
            else begin
                rsp_vec[55:48] = `CH_GT;
                do_one = 1'b1; // see R3
            end
        end else
            rsp_vec[55:48] = `CH_QUEST;
    end else begin
        rsp_len = 3'd3;
        rsp_vec[55:24] = {`CH_BANG, `ADDR_HI, `ADDR_LO, 8'h00};
        case (buf_mem[3])
            `CH_ZERO: begin
                rsp_len = 3'd5; // see R9
                rsp_vec[31:16] = timeout_reg ? {`CH_ZERO, `CH_FOUR} : {`CH_ZERO, `CH_ZERO};
            end
            `CH_ONE: begin
                do_clr = 1'b1; // see R11
            end
            `CH_TWO: begin
                rsp_len = 3'd6; // see R12
                rsp_vec[31:8] = {(en_reg ? `CH_ONE : `CH_ZERO), hexchar(iv_reg[7:4]), hexchar(iv_reg[3:0])};
            end
            `CH_THREE: begin
                if ((buf_mem[4] == `CH_ZERO || buf_mem[4] == `CH_ONE) &&
                    !v_hi[4] && !v_lo[4] && val != 8'h00)
                    do_set = 1'b1; // see R13 see R14
                else
                    rsp_vec[55:48] = `CH_QUEST; // see R18
            end
            `CH_FIVE: begin
                do_save_p = (buf_mem[4] == `CH_P); // see R21
                do_save_s = (buf_mem[4] == `CH_S);
                if (!do_save_p && !do_save_s)
                    rsp_vec[55:48] = `CH_QUEST;
            end
            default: begin
                rsp_vec[55:48] = `CH_QUEST; // see R18
            end
        endcase
    end
    rsp_vec = rsp_vec | ({48'h0, `CH_CR} << (8 * (6 - rsp_len)));
end

// ****************************************
// Receive buffer and reply shifter
// ****************************************
wire       rx_take  = RX_VALID_I && rx_ready_reg;
wire       rx_end   = rx_take && RX_DATA_I == `CH_CR;
wire       tx_fire  = tx_valid_reg && TX_READY_I;
wire       tx_load  = pend_reg && rsp_len != 3'd0;
wire [2:0] left_next = tx_load ? rsp_len + 3'd1 :
                       (tx_fire ? tx_left_reg - 3'd1 : tx_left_reg);

// Collect bytes, answer after carriage return
always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        cnt_reg <= 4'h0;
        ovf_reg <= 1'b0;
        pend_reg <= 1'b0;
        tx_vec_reg <= 56'h0;
        tx_left_reg <= 3'd0;
        tx_valid_reg <= 1'b0;
        rx_ready_reg <= 1'b0;
    end else begin
        pend_reg <= rx_end;
        if (pend_reg) begin
            cnt_reg <= 4'h0;
            ovf_reg <= 1'b0;
        end else if (rx_take && !rx_end) begin
            if (cnt_reg == `BUF_DEPTH)
                ovf_reg <= 1'b1; // Too long, dropped as a syntax error
            else
                cnt_reg <= cnt_reg + 4'h1;
        end
        if (tx_load)
            tx_vec_reg <= rsp_vec;
        else if (tx_fire)
            tx_vec_reg <= {tx_vec_reg[47:0], 8'h00};
        tx_left_reg <= left_next;
        tx_valid_reg <= left_next != 3'd0;
        rx_ready_reg <= !rx_end && !pend_reg && left_next == 3'd0;
    end
end

// Byte storage, no reset needed
always @(posedge CLOCK_I) begin
    if (rx_take && !rx_end && cnt_reg < `BUF_DEPTH)
        buf_mem[cnt_reg] <= RX_DATA_I;
end

// ****************************************
// Host watchdog and outputs
// ****************************************
wire step_done = {8'h00, step_cnt_reg} == STEP_END;
wire expire    = en_reg && !timeout_reg && step_done && iv_cnt_reg + 8'h01 >= iv_reg;
wire apb_wr    = PSEL_I && PENABLE_I && pready_reg && PWRITE_I;
wire kick_now  = pend_reg && (do_kick || do_set);

// Outputs, configuration, counters and indicator
always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        start_reg <= 1'b1;
        dout_reg <= `RST_PWRON;
        safe_reg <= `RST_SAFE;
        pwron_reg <= `RST_PWRON;
        en_reg <= `RST_EN;
        iv_reg <= `RST_IV;
        timeout_reg <= 1'b0;
        step_cnt_reg <= 24'h0;
        iv_cnt_reg <= 8'h00;
        led_reg <= 1'b0;
    end else begin
        start_reg <= 1'b0;
        // Restore persistent status after reset release
        if (start_reg) begin
            timeout_reg <= WDT_NV_STATUS_I; // see R10
            dout_reg <= WDT_NV_STATUS_I ? safe_reg : pwron_reg; // see R19
        end else if (expire) begin
            timeout_reg <= 1'b1; // see R15
            dout_reg <= safe_reg; // see R19
        end else if (pend_reg && do_clr)
            timeout_reg <= 1'b0; // see R11 see R10
        if (pend_reg && do_all && !expire)
            dout_reg <= val & CH_MASK; // see R2
        if (pend_reg && do_one && !expire)
            dout_reg <= buf_mem[6][0] ? (dout_reg | one_mask) : (dout_reg & ~one_mask); // see R3
        // Enable and interval
        if (expire)
            en_reg <= 1'b0; // see R16
        else if (pend_reg && do_set) begin
            en_reg <= buf_mem[4][0];
            iv_reg <= val; // see R13
        end else if (apb_wr && PADDR_I == `OFS_CTRL) begin
            en_reg <= PWDATA_I[`CTRL_EN_BIT];
            if (PWDATA_I[`CTRL_IV_LSB +: 8] != 8'h00)
                iv_reg <= PWDATA_I[`CTRL_IV_LSB +: 8];
        end
        // Stored values
        if (pend_reg && do_save_p)
            pwron_reg <= dout_reg; // see R21
        else if (apb_wr && PADDR_I == `OFS_PWRON)
            pwron_reg <= PWDATA_I[7:0] & CH_MASK;
        if (pend_reg && do_save_s)
            safe_reg <= dout_reg; // see R21
        else if (apb_wr && PADDR_I == `OFS_SAFE)
            safe_reg <= PWDATA_I[7:0] & CH_MASK;
        // Step counter runs while watching or flashing
        if (kick_now || !(en_reg || timeout_reg) || step_done)
            step_cnt_reg <= 24'h0; // see R23
        else
            step_cnt_reg <= step_cnt_reg + 24'h1;
        if (kick_now || !en_reg || expire)
            iv_cnt_reg <= 8'h00; // see R23
        else if (step_done)
            iv_cnt_reg <= iv_cnt_reg + 8'h01; // see R14
        // Flash while timed out, dark in the same edge as the clear
        if (!timeout_reg || (pend_reg && do_clr))
            led_reg <= 1'b0; // see R17
        else if (step_done)
            led_reg <= !led_reg; // see R15
    end
end

// ****************************************
// APB slave
// ****************************************
// One wait state, then answer
always @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
        pready_reg <= 1'b0;
        prdata_reg <= 32'h0;
        pslverr_reg <= 1'b0;
    end else begin
        pready_reg <= PSEL_I && PENABLE_I && !pready_reg;
        prdata_reg <= 32'h0;
        pslverr_reg <= 1'b0;
        if (PSEL_I && PENABLE_I && !pready_reg) begin
            case (PADDR_I)
                `OFS_CTRL:   prdata_reg <= {16'h0, iv_reg, 7'h0, en_reg};
                `OFS_STATUS: prdata_reg <= {16'h0, dout_reg, 7'h0, timeout_reg};
                `OFS_SAFE:   prdata_reg <= {24'h0, safe_reg};
                `OFS_PWRON:  prdata_reg <= {24'h0, pwron_reg};
                default:     pslverr_reg <= 1'b1;
            endcase
        end
    end
end

// ****************************************
// Output ports
// ****************************************
assign RX_READY_O      = rx_ready_reg;
assign TX_DATA_O       = tx_vec_reg[55:48];
assign TX_VALID_O      = tx_valid_reg;
assign PRDATA_O        = prdata_reg;
assign PREADY_O        = pready_reg;
assign PSLVERR_O       = pslverr_reg;
assign DOUT_O          = dout_reg;
assign LED_O           = led_reg;
assign WDT_NV_STATUS_O = timeout_reg;

endmodule // wdt_dout_cmd

// file: tb/wdt_dout_cmd_monitor.sv
// Concurrent checks on the ports of the command interpreter
`timescale 1ns/10ps
module wdt_dout_cmd_monitor #(
    parameter CH_COUNT    = 8,
    parameter STEP_CYCLES = 20
) (
    // Clock and reset
    input wire        CLOCK_I,
    input wire        RST_N_I,
    // Byte streams
    input wire [7:0]  RX_DATA_I,
    input wire        RX_VALID_I,
    input wire        RX_READY_O,
    input wire [7:0]  TX_DATA_O,
    input wire        TX_VALID_O,
    input wire        TX_READY_I,
    // APB
    input wire        PSEL_I,
    input wire        PENABLE_I,
    input wire        PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire [31:0] PRDATA_O,
    input wire        PREADY_O,
    input wire        PSLVERR_O,
    // Outputs and status
    input wire [7:0]  DOUT_O,
    input wire        LED_O,
    input wire        WDT_NV_STATUS_I,
    input wire        WDT_NV_STATUS_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    logic        led_reg;
    int unsigned led_cnt_reg;

    // Cycles since the indicator last changed while timed out
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            led_reg     <= 1'b0;
            led_cnt_reg <= 0;
        end else begin
            led_reg     <= LED_O;
            led_cnt_reg <= (!WDT_NV_STATUS_O || LED_O != led_reg) ? 0 : led_cnt_reg + 1;
        end
    end

    apb_wait_a: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
        else $error("APB answer late");
    apb_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("PREADY longer than one cycle");
    apb_err_a: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
        else $error("PSLVERR without PREADY");
    tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
        else $error("Reply byte dropped");
    rx_block_a: assert property (TX_VALID_O |-> !RX_READY_O)
        else $error("Accepting bytes during reply");
    cr_pause_a: assert property (RX_VALID_I && RX_READY_O && RX_DATA_I == 8'h0d |=> !RX_READY_O [*2])
        else $error("No pause after carriage return");
    reply_end_a: assert property (TX_VALID_O && TX_READY_I && TX_DATA_O == 8'h0d |=> !TX_VALID_O && RX_READY_O)
        else $error("Reply not closed after carriage return");
    led_off_a: assert property (!WDT_NV_STATUS_O |-> !LED_O)
        else $error("Indicator on without timeout");
    led_flash_a: assert property (led_cnt_reg <= STEP_CYCLES + 1)
        else $error("Indicator not flashing");
    dout_range_a: assert property ((DOUT_O >> CH_COUNT) == 8'h00)
        else $error("Output beyond channel count");
    cover property (WDT_NV_STATUS_O && $rose(LED_O));
endmodule // wdt_dout_cmd_monitor

bind wdt_dout_cmd wdt_dout_cmd_monitor #(.CH_COUNT(CH_COUNT), .STEP_CYCLES(STEP_CYCLES)) mon_u (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .RX_DATA_I(RX_DATA_I), .RX_VALID_I(RX_VALID_I),
    .RX_READY_O(RX_READY_O), .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .TX_READY_I(TX_READY_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DOUT_O(DOUT_O), .LED_O(LED_O),
    .WDT_NV_STATUS_I(WDT_NV_STATUS_I), .WDT_NV_STATUS_O(WDT_NV_STATUS_O));

// file: tb/host_model.sv
// Host side model: sends command frames, collects replies with random stalls
`timescale 1ns/10ps
module host_model (
    // Clock
    input  wire        clk_i,
    // Commands to the device
    output logic [7:0] rx_data_o,
    output logic       rx_valid_o,
    input  wire        rx_ready_i,
    // Replies from the device
    input  wire [7:0]  tx_data_i,
    input  wire        tx_valid_i,
    output logic       tx_ready_o
);
    initial begin
        rx_data_o  = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b1;
    end

    // Send one frame, return the reply text without its carriage return
    task automatic cmd(input string s, input bit chk, output string r);
        string      f;
        logic [7:0] sum;
        int         n;
        bit         bad;
        bad = 1'b0;
        f   = s;
        sum = 8'h00;
        r   = "";
        foreach (s[i]) sum += s[i];
        if (chk) f = {f, $sformatf("%02X", sum)};
        f = {f, "\r"};
        @(posedge clk_i);
        foreach (f[i]) begin
            rx_data_o  <= f[i];
            rx_valid_o <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (rx_ready_i !== 1'b1 && n < 50);
            if (rx_ready_i !== 1'b1) bad = 1'b1;
        end
        // Released line shows the inverse of the last byte
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~f[f.len()-1];
        n = 0;
        while (1) begin
            @(posedge clk_i);
            n++;
            if (tx_valid_i === 1'b1 && tx_ready_o) begin
                if (tx_data_i == 8'h0d) break;
                r = $sformatf("%s%c", r, tx_data_i);
            end
            if (r.len() == 0 && tx_valid_i !== 1'b1 && n > 12) break;
            if (n > 300) begin
                r = "TIMEOUT";
                break;
            end
            tx_ready_o <= 1'($urandom_range(0, 1));
        end
        tx_ready_o <= 1'b1;
        // A byte never taken spoils the whole frame
        if (bad) r = "TIMEOUT";
    endtask
endmodule // host_model

// file: tb/testbench.sv
// Self-checking bench for the output and host watchdog command interpreter
`timescale 1ns/10ps
module testbench;
    localparam int STEP = 20;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  rx_data, tx_data, dout, safe, v;
    logic        rx_valid, rx_ready, tx_valid, tx_ready, led, nv_in, nv_out, err, l0;
    int          mismatches, checks, n;

    // ****************************************
    // Design, host model and clock
    // ****************************************
    wdt_dout_cmd #(.CH_COUNT(6), .STEP_CYCLES(STEP)) dut_u (
        .CLOCK_I(clk), .RST_N_I(rst_n), .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready),
        .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .DOUT_O(dout), .LED_O(led), .WDT_NV_STATUS_I(nv_in), .WDT_NV_STATUS_O(nv_out));
    host_model host_u (.clk_i(clk), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
        .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
    always #5 clk = ~clk;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Pack up to eight characters into a word
    function automatic logic [63:0] s2v(input string s);
        logic [63:0] w;
        w = 64'h0;
        foreach (s[i]) w = {w[55:0], s[i]};
        return w;
    endfunction
    // Checksum on or off at random unless forced
    task automatic tx(input string s, input int chk, input string exp);
        string r;
        host_u.cmd(s, (chk == 2) ? 1'($urandom_range(0, 1)) : chk[0], r);
        check(s, s2v(r), s2v(exp));
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            end_of_test();
        end
    endtask
    function automatic string all_reply(input logic [7:0] x);
        return (x >> 6) ? "?" : ">";
    endfunction
    task automatic reset_dut;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // Overall run limit
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {clk, psel, penable, pwrite, paddr, pwdata, nv_in, mismatches, checks} = '0;
        rst_n = 1'b0;
        void'($urandom(53245));
        reset_dut();
        check("dout reset", dout, 8'h00);
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl reset", {err, rd}, 33'h0_0000_6400);
        safe = 8'($urandom_range(1, 63));
        apb(1'b1, 12'h008, {24'h0, safe});
        apb(1'b0, 12'h008, 32'h0);
        check("safe reg", {err, rd}, {25'h0, safe});
        apb(1'b1, 12'h010, 32'hffff_ffff);
        check("unmapped", {err, rd}, 33'h1_0000_0000);
        // Multi-channel set, random and boundary values
        repeat (8) begin
            v = ($urandom_range(0, 3) == 0) ? 8'h40 : 8'($urandom_range(0, 63));
            l0 = (v >> 6) != 0;
            if (l0) v = 8'h40 | v;
            tx($sformatf("#0100%02X", v), 2, all_reply(v));
            if (!l0) check("dout all", dout, v);
        end
        tx("#010005", 2, ">");
        check("dout 05", dout, 8'h05);
        tx("#0100G1", 0, "");
        tx("#0200FF", 2, "");
        tx("#01000100", 0, "");
        // Single-channel set over every channel, then bad ones
        for (int ch = 0; ch < 6; ch++) begin
            v = dout;
            v[ch] = 1'($urandom_range(0, 1));
            tx($sformatf("#011%0d0%0d", ch, v[ch]), 2, ">");
            check("dout one", dout, v);
        end
        tx("#011601", 2, "?");
        tx("#011102", 2, "?");
        // Watchdog configuration
        tx("~**", 2, "");
        tx("~010", 2, "!0100");
        tx("~013200", 2, "?01");
        tx("~013100", 2, "?01");
        tx("~0131FF", 2, "!01");
        tx("~012", 2, "!011FF");
        tx("~013103", 2, "!01");
        repeat (6) begin
            repeat (20) @(posedge clk);
            tx("~**", 2, "");
        end
        check("no expiry", nv_out, 1'b0);
        // Expiry without keep-alive
        n = 0;
        while (nv_out !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check("expired", nv_out, 1'b1);
        check("dout safe", dout, safe);
        tx("~010", 2, "!0104");
        tx("~012", 2, "!01003");
        tx("#01000F", 2, "!");
        tx("#011001", 2, "!");
        check("dout kept safe", dout, safe);
        l0 = led;
        n = 0;
        while (led === l0 && n < 3 * STEP) begin
            @(posedge clk);
            n++;
        end
        check("led flashes", n <= STEP + 1, 1'b1);
        tx("~011", 2, "!01");
        check("led off", led, 1'b0);
        tx("~010", 2, "!0100");
        tx("#01000F", 2, ">");
        check("dout after clear", dout, 8'h0f);
        apb(1'b0, 12'h004, 32'h0);
        check("status reg", {err, rd}, 33'h0_0000_0f00);
        // Capture of stored values and invalid forms
        tx("~015S", 2, "!01");
        apb(1'b0, 12'h008, 32'h0);
        check("safe captured", rd, 32'h0f);
        tx("~015P", 2, "!01");
        apb(1'b0, 12'h00c, 32'h0);
        check("pwron captured", rd, 32'h0f);
        tx("~015Q", 2, "?01");
        tx("~019", 2, "?01");
        apb(1'b1, 12'h000, 32'h0000_0500);
        tx("~012", 2, "!01005");
        // Status survives a reset through the store
        nv_in <= 1'b1;
        reset_dut();
        check("status kept", nv_out, 1'b1);
        tx("~010", 2, "!0104");
        end_of_test();
    end
endmodule // testbench
